// file: memory_map_bank_decode_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module memory_map_bank_decode_tb_top;
  logic core_clk, reset_n, fetch_advance, pc_load, irq_take;
  logic [12:0] pc_load_addr, pc_q, ep;
  logic [13:0] insn_q, pm [2048];
  logic [7:0]  data_rdata, sfr_addr, sfr_wdata, sfr_rdata, status_q, ptr_q, r;
  logic [7:0]  rb [512], sm [256] = '{default: 8'h00};
  logic        data_rvalid_q, sfr_sel, sfr_write, s;
  logic [31:0] w;
  logic [8:0]  f;
  logic [6:0]  a2, tab [6] = '{7'h02, 7'h05, 7'h0a, 7'h0b, 7'h1f, 7'h01};
  mmbd_pkg::mmbd_prog_wr_s  prog_wr;
  mmbd_pkg::mmbd_data_req_s data_req;
  int seed = 48, mismatches = 0, checked = 0, steps = 0;

  mmbd_top DUT (.core_clk(core_clk), .reset_n(reset_n),
    .fetch_advance(fetch_advance), .pc_load(pc_load),
    .pc_load_addr(pc_load_addr), .irq_take(irq_take), .prog_wr(prog_wr),
    .pc_q(pc_q), .insn_q(insn_q), .data_req(data_req),
    .data_rdata(data_rdata), .data_rvalid_q(data_rvalid_q),
    .sfr_sel(sfr_sel), .sfr_write(sfr_write), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .status_q(status_q),
    .indirect_pointer_q(ptr_q));
  mmbd_sfr_model u_sfr (.core_clk(core_clk), .sfr_sel(sfr_sel),
    .sfr_write(sfr_write), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata));

  // Clock and step counter
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (fetch_advance === 1'b1) steps++;

  // Expected storage index, bank 1 top mirrors bank 0
  function automatic int ridx(input logic [8:0] x);
    return (x[8:4] == 5'h0f) ? int'(x) - 128 : int'(x);
  endfunction
  function automatic int sidx(input logic [8:0] x);
    return (x[6:0] == 7'h02 || x[6:0] == 7'h0a || x[6:0] == 7'h0b)
      ? int'(x[6:0]) : int'(x[7:0]);
  endfunction

  task automatic cmp_b(input logic [7:0] g, input logic [7:0] e,
                       input string m);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic cmp_w(input logic [13:0] g, input logic [13:0] e,
                       input string m);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // One data access, answer sampled after the taking edge
  task automatic acc(input logic wr, input logic [6:0] ad,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge core_clk);
    data_req <= '{1'b1, wr, ad, d};
    @(posedge core_clk);
    data_req <= '0;
    #1 q = data_rdata;
    cmp_b({7'h0, data_rvalid_q}, {7'h0, !wr}, "read answer");
  endtask
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Watchdog
  initial begin
    #50000;
    mismatches++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    {reset_n, fetch_advance, pc_load, irq_take} = 4'h0;
    pc_load_addr = 13'h0000;
    prog_wr = '0;
    data_req = '0;
    repeat (15) @(posedge core_clk);
    #1 cmp_w({1'b0, pc_q}, 14'h0000, "reset pc");
    cmp_w(insn_q, 14'h0000, "reset word");
    cmp_b(status_q, 8'h00, "reset status");
    @(posedge core_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      w = $random(seed);
      pm[11'(i - 2)] = w[13:0];
      @(posedge core_clk);
      prog_wr <= '{1'b1, {2'(i), 11'(i - 2)}, w[13:0]};
    end
    @(posedge core_clk);
    prog_wr <= '0;
    pc_load <= 1'b1;
    pc_load_addr <= 13'h1ffe;
    @(posedge core_clk);
    pc_load <= 1'b0;
    fetch_advance <= 1'b1;
    ep = 13'h1ffe;
    for (int i = 0; i < 10; i++) begin
      @(posedge core_clk);
      #1 cmp_w(insn_q, pm[ep[10:0]], "fetch word");
      ep = ep + 13'h0001;
      cmp_w({1'b0, pc_q}, {1'b0, ep}, "pc step");
    end
    @(posedge core_clk);
    irq_take <= 1'b1;
    pc_load <= 1'b1;
    @(posedge core_clk);
    {irq_take, pc_load, fetch_advance} <= 3'h0;
    #1 cmp_w({1'b0, pc_q}, 14'h0004, "irq vector");
    @(posedge core_clk);
    #1 cmp_w(insn_q, pm[4], "vector word");
    @(posedge core_clk);
    steps = 0;
    fetch_advance <= 1'b1;
    for (int i = 0; i < 192; i++) begin
      w = $random(seed);
      f = 9'((i / 96) * 128 + 32 + i % 96);
      if (i % 96 == 0) acc(1'b1, 7'h03, {2'b00, f[7], 5'h00}, r);
      acc(1'b1, f[6:0], w[7:0], r);
      rb[ridx(f)] = w[7:0];
    end
    for (int i = 0; i < 72; i++) begin
      w = $random(seed);
      s = i[0];
      f = {1'b0, w[8], s ? tab[(i / 2) % 6] : (w[6:0] | 7'h20)};
      acc(1'b1, 7'h03, {2'b00, w[8], 5'h00}, r);
      cmp_b(status_q, {2'b00, w[8], 5'h00}, "bank bits");
      a2 = f[6:0];
      if (w[11]) begin
        acc(1'b1, 7'h04, f[7:0], r);
        cmp_b(ptr_q, f[7:0], "pointer");
        a2 = 7'h00;
      end
      acc(w[10], a2, w[23:16], r);
      if (w[10] && s) sm[sidx(f)] = w[23:16];
      else if (w[10]) rb[ridx(f)] = w[23:16];
      else cmp_b(r, s ? sm[sidx(f)] : rb[ridx(f)], "data read");
    end
    @(posedge core_clk);
    fetch_advance <= 1'b0;
    #1 cmp_w({1'b0, pc_q}, 14'(4 + steps), "fetch beside data");
    acc(1'b1, 7'h04, 8'h03, r);
    // upper bank bit set on purpose
    acc(1'b1, 7'h03, 8'h40, r);
    acc(1'b1, 7'h25, ~rb[37], r);
    acc(1'b0, 7'h25, 8'h00, r);
    cmp_b(r, 8'h00, "absent bank read");
    acc(1'b0, 7'h05, 8'h00, r);
    cmp_b(r, 8'h00, "absent bank special");
    acc(1'b1, 7'h00, 8'h00, r);
    acc(1'b0, 7'h25, 8'h00, r);
    cmp_b(r, rb[37], "bank 0 kept");
    report_and_stop();
  end
endmodule // memory_map_bank_decode_tb_top
`default_nettype wire

// file: mmbd_defines.svh
`ifndef MMBD_DEFINES_SVH
`define MMBD_DEFINES_SVH

// ----------------------------------------------------------------
// Program space
// ----------------------------------------------------------------
`define MMBD_PC_W        13
`define MMBD_PROG_AW     11
`define MMBD_PROG_DEPTH  2048
`define MMBD_INSN_W      14
`define MMBD_RESET_VEC   13'h0000
`define MMBD_IRQ_VEC     13'h0004
`define MMBD_PC_STEP     13'h0001

// ----------------------------------------------------------------
// Data space
// ----------------------------------------------------------------
`define MMBD_OFF_W       7
`define MMBD_FULL_W      9
`define MMBD_DATA_W      8
`define MMBD_BANK_HI_BIT 6
`define MMBD_BANK_LO_BIT 5
`define MMBD_PTR_HI_BIT  7
`define MMBD_SFR_TOP     7'h1f
`define MMBD_GPR_BASE    7'h20
`define MMBD_MIRROR_BASE 7'h70
`define MMBD_OFF_INDIR   7'h00
`define MMBD_OFF_MIRR_A  7'h02
`define MMBD_OFF_STATUS  7'h03
`define MMBD_OFF_POINTER 7'h04
`define MMBD_OFF_MIRR_B  7'h0a
`define MMBD_OFF_MIRR_C  7'h0b
`define MMBD_GPR_AW      8
`define MMBD_GPR_DEPTH   176
`define MMBD_GPR_B1_BASE 8'h60
`define MMBD_STATUS_RST  8'h00
`define MMBD_POINTER_RST 8'h00
`define MMBD_ZERO_BYTE   8'h00

`endif

// file: mmbd_pkg.sv
`default_nettype none
`include "mmbd_defines.svh"

package mmbd_pkg;

  // Data access request from the core
  typedef struct packed {
    logic                      valid;
    logic                      write;
    logic [`MMBD_OFF_W-1:0]    addr;
    logic [`MMBD_DATA_W-1:0]   wdata;
  } mmbd_data_req_s;

  // Program memory load port
  typedef struct packed {
    logic                      en;
    logic [`MMBD_PC_W-1:0]     addr;
    logic [`MMBD_INSN_W-1:0]   data;
  } mmbd_prog_wr_s;

  // Target of a resolved data address
  typedef enum logic [2:0] {
    MMBD_REG_NONE    = 3'b000,
    MMBD_REG_SFR     = 3'b001,
    MMBD_REG_GPR     = 3'b010,
    MMBD_REG_STATUS  = 3'b011,
    MMBD_REG_POINTER = 3'b100
  } mmbd_region_e;

endpackage : mmbd_pkg

`default_nettype wire

// file: mmbd_ram.sv
`timescale 1ns/10ps
`default_nettype none

// Single write, single registered read memory
module mmbd_ram #(
  parameter int W     = 8,
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic          core_clk,
  input  wire logic          reset_n,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [W-1:0]  rd_data_q
);

  logic [W-1:0] mem [DEPTH];

  // Storage write
  always_ff @(posedge core_clk) begin
    if (wr_en && (int'(wr_addr) < DEPTH)) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read, old data on collision
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rd_data_q <= '0;
    end else if (int'(rd_addr) < DEPTH) begin
      rd_data_q <= mem[rd_addr];
    end else begin
      rd_data_q <= '0;
    end
  end

endmodule // mmbd_ram

`default_nettype wire

// file: mmbd_sfr_model.sv
`timescale 1ns/10ps
`default_nettype none

// External special register file
module mmbd_sfr_model (
  input wire logic       core_clk,
  input wire logic       sfr_sel,
  input wire logic       sfr_write,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic     [7:0] sfr_rdata
);
  logic [7:0] regs_q [256] = '{default: 8'h00};
  logic [7:0] junk_q = 8'h5a;
  always @(posedge core_clk) begin
    junk_q <= ~junk_q + 8'h35;
    if (sfr_sel && sfr_write) regs_q[sfr_addr] <= sfr_wdata;
  end
  // Idle bus shows a changing pattern
  assign sfr_rdata = sfr_sel ? regs_q[sfr_addr] : junk_q;
endmodule // mmbd_sfr_model
`default_nettype wire

// file: mmbd_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "mmbd_defines.svh"

// Notes on behaviour
// RQ1: Program fetch and data access use separate buses, same cycle.
// RQ2: Program counter is 13 bits, covering 8K fourteen-bit words.
// RQ3: Only 2K words exist; higher fetch addresses wrap onto them.
// RQ4: Reset loads the program counter with address zero.
// RQ5: Taking an interrupt loads the program counter with address four.
// RQ6: Status bits 6:5 pick the bank; banks 2 and 3 are absent.
// RQ7: Software keeps status bit 6 clear for forward compatibility.
// RQ8: Each bank spans 128 byte offsets, 00h to 7Fh.
// RQ9: Low offsets decode to special registers, higher ones to RAM.
// RQ10: Every present bank has special registers at its low offsets.
// RQ11: Top 16 RAM bytes and busy special registers mirror into bank 1.
// RQ12: Data space reachable directly or through the pointer register.
// RQ13: Direct address is bank bits placed above the 7-bit offset.
module mmbd_top #(
  parameter int PROG_DEPTH = `MMBD_PROG_DEPTH,
  parameter int GPR_DEPTH  = `MMBD_GPR_DEPTH
) (
  input  wire logic                        core_clk,
  input  wire logic                        reset_n,
  input  wire logic                        fetch_advance,
  input  wire logic                        pc_load,
  input  wire logic [`MMBD_PC_W-1:0]       pc_load_addr,
  input  wire logic                        irq_take,
  input  wire mmbd_pkg::mmbd_prog_wr_s     prog_wr,
  output logic      [`MMBD_PC_W-1:0]       pc_q,
  output logic      [`MMBD_INSN_W-1:0]     insn_q,
  input  wire mmbd_pkg::mmbd_data_req_s    data_req,
  output logic      [`MMBD_DATA_W-1:0]     data_rdata,
  output logic                             data_rvalid_q,
  output logic                             sfr_sel,
  output logic                             sfr_write,
  output logic      [`MMBD_DATA_W-1:0]     sfr_addr,
  output logic      [`MMBD_DATA_W-1:0]     sfr_wdata,
  input  wire logic [`MMBD_DATA_W-1:0]     sfr_rdata,
  output logic      [`MMBD_DATA_W-1:0]     status_q,
  output logic      [`MMBD_DATA_W-1:0]     indirect_pointer_q
);

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------

  // Classify a full bank plus offset address
  function automatic mmbd_pkg::mmbd_region_e region_of(
    input logic [`MMBD_FULL_W-1:0] fa
  );
    mmbd_pkg::mmbd_region_e r;
    logic [`MMBD_OFF_W-1:0] off;
    off = fa[`MMBD_OFF_W-1:0];
    r   = mmbd_pkg::MMBD_REG_GPR;
    // RQ6 absent banks
    if (fa[`MMBD_FULL_W-1]) begin
      r = mmbd_pkg::MMBD_REG_NONE;
    end else if (off == `MMBD_OFF_INDIR) begin
      r = mmbd_pkg::MMBD_REG_NONE;
    end else if (off == `MMBD_OFF_STATUS) begin
      r = mmbd_pkg::MMBD_REG_STATUS;
    end else if (off == `MMBD_OFF_POINTER) begin
      r = mmbd_pkg::MMBD_REG_POINTER;
    // RQ9 RQ10 special low region
    end else if (off <= `MMBD_SFR_TOP) begin
      r = mmbd_pkg::MMBD_REG_SFR;
    end
    return r;
  endfunction

  // RAM index of a general purpose byte
  function automatic logic [`MMBD_GPR_AW-1:0] gpr_index(
    input logic [`MMBD_FULL_W-1:0] fa
  );
    logic [`MMBD_GPR_AW-1:0] rel;
    rel = {1'b0, fa[`MMBD_OFF_W-1:0]} - {1'b0, `MMBD_GPR_BASE};
    // RQ11 top bytes shared
    if (fa[`MMBD_OFF_W] && (fa[`MMBD_OFF_W-1:0] < `MMBD_MIRROR_BASE)) begin
      return rel + `MMBD_GPR_B1_BASE;
    end
    return rel;
  endfunction

  // Busy special registers seen from both banks
  function automatic logic sfr_mirrored(input logic [`MMBD_OFF_W-1:0] off);
    return (off == `MMBD_OFF_MIRR_A) || (off == `MMBD_OFF_MIRR_B) ||
           (off == `MMBD_OFF_MIRR_C);
  endfunction

  // ----------------------------------------------------------------
  // Program counter and fetch
  // ----------------------------------------------------------------

  // Vector loads over jumps over advance
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      // RQ4 reset vector
      pc_q <= `MMBD_RESET_VEC;
    end else if (irq_take) begin
      // RQ5 interrupt vector
      pc_q <= `MMBD_IRQ_VEC;
    end else if (pc_load) begin
      pc_q <= pc_load_addr;
    end else if (fetch_advance) begin
      // RQ2 full 13-bit count
      pc_q <= pc_q + `MMBD_PC_STEP;
    end
  end

  // RQ3 wrap by dropping upper bits
  logic [`MMBD_PROG_AW-1:0] fetch_addr;
  logic [`MMBD_PROG_AW-1:0] load_addr;
  assign fetch_addr = pc_q[`MMBD_PROG_AW-1:0];
  assign load_addr  = prog_wr.addr[`MMBD_PROG_AW-1:0];

  // RQ1 program bus of its own
  mmbd_ram #(
    .W     (`MMBD_INSN_W),
    .DEPTH (PROG_DEPTH),
    .AW    (`MMBD_PROG_AW)
  ) u_prog_mem (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .wr_en     (prog_wr.en),
    .wr_addr   (load_addr),
    .wr_data   (prog_wr.data),
    .rd_addr   (fetch_addr),
    .rd_data_q (insn_q)
  );

  // ----------------------------------------------------------------
  // Data address formation
  // ----------------------------------------------------------------

  logic [1:0]                bank_sel;
  logic [`MMBD_FULL_W-1:0]   direct_addr;
  logic [`MMBD_FULL_W-1:0]   full_addr;
  mmbd_pkg::mmbd_region_e    region;
  logic [`MMBD_GPR_AW-1:0]   gpr_addr;
  logic                      gpr_wr;

  // RQ6 bank bits from status
  assign bank_sel = {status_q[`MMBD_BANK_HI_BIT], status_q[`MMBD_BANK_LO_BIT]};

  // RQ13 bank above direct offset
  assign direct_addr = {bank_sel, data_req.addr};

  // RQ12 indirect through pointer
  assign full_addr = (data_req.addr == `MMBD_OFF_INDIR) ?
                     {status_q[`MMBD_PTR_HI_BIT], indirect_pointer_q} :
                     direct_addr;

  // RQ8 seven-bit offset within bank
  assign region   = region_of(full_addr);
  assign gpr_addr = gpr_index(full_addr);
  assign gpr_wr   = data_req.valid && data_req.write &&
                    (region == mmbd_pkg::MMBD_REG_GPR);

  // ----------------------------------------------------------------
  // Status and pointer registers
  // ----------------------------------------------------------------

  // Status write, seen in both banks
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      status_q <= `MMBD_STATUS_RST;
    end else if (data_req.valid && data_req.write &&
                 (region == mmbd_pkg::MMBD_REG_STATUS)) begin
      status_q <= data_req.wdata;
    end
  end

  // Pointer write, seen in both banks
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      indirect_pointer_q <= `MMBD_POINTER_RST;
    end else if (data_req.valid && data_req.write &&
                 (region == mmbd_pkg::MMBD_REG_POINTER)) begin
      indirect_pointer_q <= data_req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // General purpose RAM
  // ----------------------------------------------------------------

  logic [`MMBD_DATA_W-1:0] gpr_rd_q;

  // RQ1 data bus of its own
  mmbd_ram #(
    .W     (`MMBD_DATA_W),
    .DEPTH (GPR_DEPTH),
    .AW    (`MMBD_GPR_AW)
  ) u_gpr_mem (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .wr_en     (gpr_wr),
    .wr_addr   (gpr_addr),
    .wr_data   (data_req.wdata),
    .rd_addr   (gpr_addr),
    .rd_data_q (gpr_rd_q)
  );

  // ----------------------------------------------------------------
  // Special register strobe
  // ----------------------------------------------------------------

  // RQ11 busy registers fold to bank 0
  assign sfr_sel   = data_req.valid && (region == mmbd_pkg::MMBD_REG_SFR);
  assign sfr_write = sfr_sel && data_req.write;
  assign sfr_addr  = {full_addr[`MMBD_OFF_W] &&
                      !sfr_mirrored(full_addr[`MMBD_OFF_W-1:0]),
                      full_addr[`MMBD_OFF_W-1:0]};
  assign sfr_wdata = data_req.wdata;

  // ----------------------------------------------------------------
  // Read return
  // ----------------------------------------------------------------

  logic                    rd_gpr_q;
  logic [`MMBD_DATA_W-1:0] rd_other_q;

  // Answer one cycle after every read request
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      data_rvalid_q <= 1'b0;
    end else begin
      data_rvalid_q <= data_req.valid && !data_req.write;
    end
  end

  // Capture non-RAM read value
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rd_gpr_q   <= 1'b0;
      rd_other_q <= `MMBD_ZERO_BYTE;
    end else begin
      rd_gpr_q <= (region == mmbd_pkg::MMBD_REG_GPR);
      case (region)
        mmbd_pkg::MMBD_REG_SFR:     rd_other_q <= sfr_rdata;
        mmbd_pkg::MMBD_REG_STATUS:  rd_other_q <= status_q;
        mmbd_pkg::MMBD_REG_POINTER: rd_other_q <= indirect_pointer_q;
        default:                    rd_other_q <= `MMBD_ZERO_BYTE;
      endcase
    end
  end

  // Select between flopped sources
  assign data_rdata = rd_gpr_q ? gpr_rd_q : rd_other_q;

endmodule // mmbd_top

`default_nettype wire

// file: mmbd_top_props.sv
`timescale 1ns/10ps
`default_nettype none
`include "mmbd_defines.svh"

// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module mmbd_props (
  input wire logic                    core_clk,
  input wire logic                    reset_n,
  input wire logic                    fetch_advance,
  input wire logic                    pc_load,
  input wire logic [12:0]             pc_load_addr,
  input wire logic                    irq_take,
  input wire logic [12:0]             pc_q,
  input wire mmbd_pkg::mmbd_data_req_s data_req,
  input wire logic                    data_rvalid_q,
  input wire logic                    sfr_sel,
  input wire logic [7:0]              sfr_addr,
  input wire logic [7:0]              status_q,
  input wire logic [7:0]              indirect_pointer_q
);
  logic [6:0] a;
  logic       dv;
  logic       mir;
  // Request fields and mirrored offsets
  assign a   = data_req.addr;
  assign dv  = data_req.valid;
  assign mir = (a == 7'h02) || (a == 7'h0a) || (a == 7'h0b);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  irq_vector_a: assert property (
    irq_take |=> pc_q == 13'h0004) else $error("irq vector wrong");
  pc_jump_a: assert property (
    !irq_take && pc_load |=> pc_q == $past(pc_load_addr))
    else $error("jump target wrong");
  pc_step_a: assert property (
    !irq_take && !pc_load && fetch_advance |=> pc_q == $past(pc_q) + 13'h1)
    else $error("pc step wrong");
  pc_hold_a: assert property (
    !irq_take && !pc_load && !fetch_advance |=> $stable(pc_q))
    else $error("pc moved");
  read_answer_a: assert property (
    1'b1 |=> data_rvalid_q == $past(dv && !data_req.write))
    else $error("read answer wrong");
  bank_refuse_a: assert property (
    dv && status_q[6] && a != 7'h00 |-> !sfr_sel)
    else $error("absent bank selected");
  sfr_region_a: assert property (
    dv && !status_q[6] && a != 7'h00 && a <= 7'h1f && a != 7'h03
    && a != 7'h04 |-> sfr_sel) else $error("special reg missed");
  ram_region_a: assert property (
    dv && a >= 7'h20 |-> !sfr_sel) else $error("ram hit special");
  direct_addr_a: assert property (
    sfr_sel && a != 7'h00 && !mir |-> sfr_addr == {status_q[5], a})
    else $error("direct address wrong");
  mirror_addr_a: assert property (
    sfr_sel && mir |-> sfr_addr == {1'b0, a}) else $error("mirror wrong");
  indir_addr_a: assert property (
    sfr_sel && a == 7'h00 |-> sfr_addr[6:0] == indirect_pointer_q[6:0])
    else $error("indirect address wrong");
  status_write_a: assert property (
    dv && data_req.write && a == 7'h03 && !status_q[6]
    |=> status_q == $past(data_req.wdata)) else $error("status not written");
endmodule // mmbd_props

bind mmbd_top mmbd_props u_props (
  .core_clk(core_clk), .reset_n(reset_n), .fetch_advance(fetch_advance),
  .pc_load(pc_load), .pc_load_addr(pc_load_addr), .irq_take(irq_take),
  .pc_q(pc_q), .data_req(data_req), .data_rvalid_q(data_rvalid_q),
  .sfr_sel(sfr_sel), .sfr_addr(sfr_addr), .status_q(status_q),
  .indirect_pointer_q(indirect_pointer_q)
);
`default_nettype wire
